// ==== shared/dpd_pkg.sv ====
// constants for the dual pll divider configuration block
// Function
// RULE1: main feedback divide 1..4095, default 3072
// RULE2: aux feedback divide 4..511, default 96
// RULE3: aux divider power-down bit disables it
// RULE4: feedback phase code places lock window
// RULE5: software picks feedback phase by ratio
// RULE6: pre-divider phase code places lock window
// RULE7: input pre-divide 1..4095, default 3072
// RULE8: second-stage divide 8..511, default 24
// RULE9: second-stage prediv 1..63, zero bypasses
// RULE10: doubler selects doubled path, ignores prediv
// RULE11: oscillator select zero; one is forbidden
// RULE12: feedback bypass multiplies main by aux
// RULE13: first-stage bypass disables first pll
// RULE14: dividers pulse once per N input cycles
// RULE15: software writes both ratio bytes first
package dpd_pkg;
  // =====================================================
  // register offsets
  localparam logic [7:0] ADDR_FB_HI = 8'h00;
  localparam logic [7:0] ADDR_FB_LO = 8'h01;
  localparam logic [7:0] ADDR_AUX_LO = 8'h02;
  localparam logic [7:0] ADDR_AUX_TOP = 8'h03;
  localparam logic [7:0] ADDR_IN_HI = 8'h04;
  localparam logic [7:0] ADDR_IN_LO = 8'h05;
  localparam logic [7:0] ADDR_SS_TOP = 8'h08;
  localparam logic [7:0] ADDR_SS_LO = 8'h09;
  localparam logic [7:0] ADDR_DBL = 8'h0C;
  localparam logic [7:0] ADDR_OSC = 8'h1F;
  // =====================================================
  // field positions
  localparam int PHASE_LSB = 5;
  localparam int PD_AUX_BIT = 4;
  localparam int AUX_TOP_BIT = 7;
  localparam int FB_BYP_BIT = 0;
  localparam int DBL_BIT = 7;
  localparam int SS_TOP_BIT = 0;
  localparam int OSC_BIT = 0;
  // =====================================================
  // reset values
  localparam logic [11:0] MAIN_FB_RST = 12'hC00;
  localparam logic [8:0] AUX_FB_RST = 9'h060;
  localparam logic [11:0] IN_DIV_RST = 12'hC00;
  localparam logic [8:0] SS_RATIO_RST = 9'h018;
  localparam logic [5:0] SS_PREDIV_RST = 6'h00;
  localparam logic [2:0] PHASE_RST = 3'h0;
  // =====================================================
  // reserved-bit read masks
  localparam logic [7:0] MASK_IN_HI = 8'hEF;
  localparam logic [7:0] MASK_DBL = 8'hBF;
endpackage

// ==== design/dpd_divider.sv ====
// programmable integer divider with one-cycle output pulse
module dpd_divider #(
  parameter int WIDTH = 12
) (
  input wire logic clk_sys, // block clock
  input wire logic rst_b, // sync reset, active low
  input wire logic clk_en, // input clock edge enable
  input wire logic run, // divider enabled
  input wire logic [WIDTH-1:0] ratio, // divide ratio n
  output logic pulse // one pulse per n enables
);
  logic [WIDTH-1:0] count;
  logic [WIDTH-1:0] next_count;
  logic next_pulse;

  // =====================================================
  // counter
  always_comb
  begin
    next_count = count;
    next_pulse = 1'b0;
    if (!run)
    begin
      next_count = '0;
    end
    else if (clk_en)
    begin
      // ratio read live; a change applies to the count already in progress
      if ((count + 1'b1) >= ratio) // [RULE14]
      begin
        next_count = '0;
        next_pulse = 1'b1;
      end
      else
      begin
        next_count = WIDTH'(count + 1'b1);
      end
    end
  end

  always_ff @(posedge clk_sys)
  begin
    if (!rst_b)
    begin
      count <= '0;
      pulse <= 1'b0;
    end
    else
    begin
      count <= next_count;
      pulse <= next_pulse;
    end
  end
endmodule

// ==== design/dpd_top.sv ====
// register bank and divider chain of the two-stage clock synthesizer
module dpd_top (
  input wire logic clk_sys, // block clock, 40 MHz
  input wire logic rst_b, // sync reset, active low
  input wire logic wr_en, // config port write strobe
  input wire logic rd_en, // config port read strobe
  input wire logic [7:0] addr, // config register address
  input wire logic [7:0] wdata, // config write data
  output logic [7:0] rdata, // config read data
  input wire logic ref_en, // reference clock edge enable
  input wire logic vcxo_en, // vcxo clock edge enable
  input wire logic vco_en, // vco clock edge enable
  output logic ref_div_pulse, // reference pre-divider output
  output logic fb_div_pulse, // first-stage feedback output
  output logic aux_div_pulse, // aux feedback divider output
  output logic ss_in_pulse, // second-stage input clock pulse
  output logic ss_fb_pulse, // second-stage divider output
  output logic [2:0] feedback_phase_sel, // lock window phase
  output logic [2:0] input_prediv_phase_sel, // lock window phase
  output logic first_stage_pll_en, // first pll active
  output logic oscillator_select // vco choice
);
  import dpd_pkg::*;

  logic [11:0] main_feedback_ratio, next_main;
  logic [8:0] aux_feedback_ratio, next_aux;
  logic aux_feedback_powerdown, next_pd;
  logic feedback_bypass, next_fbyp;
  logic [11:0] input_prediv_ratio, next_in;
  logic [8:0] second_stage_ratio, next_ss;
  logic [5:0] second_stage_prediv, next_pf;
  logic freq_doubler_sel, next_dbl;
  logic osc_sel_q, next_osc;
  logic first_stage_bypass;
  logic [2:0] fb_phase_q, next_fbph;
  logic [2:0] in_phase_q, next_inph;
  logic [7:0] next_rdata;
  logic main_pulse, aux_pulse, in_pulse, pf_pulse, ss_pulse;
  logic fb_pulse_c, ss_src, dbl_pulse, next_ss_in, next_fb;
  logic vcxo_half;

  // first-stage bypass lives outside this register bank; held off
  assign first_stage_bypass = 1'b0;

  // =====================================================
  // register writes
  always_comb
  begin
    next_main = main_feedback_ratio;
    next_aux = aux_feedback_ratio;
    next_pd = aux_feedback_powerdown;
    next_fbyp = feedback_bypass;
    next_in = input_prediv_ratio;
    next_ss = second_stage_ratio;
    next_pf = second_stage_prediv;
    next_dbl = freq_doubler_sel;
    next_osc = osc_sel_q;
    next_fbph = fb_phase_q;
    next_inph = in_phase_q;
    if (wr_en)
    begin
      unique case (addr)
        ADDR_FB_HI:
        begin
          next_fbph = wdata[PHASE_LSB+:3]; // [RULE4]
          next_pd = wdata[PD_AUX_BIT]; // [RULE3]
          next_main[11:8] = wdata[3:0]; // [RULE1]
        end
        ADDR_FB_LO: next_main[7:0] = wdata; // [RULE1]
        ADDR_AUX_LO: next_aux[7:0] = wdata; // [RULE2]
        ADDR_AUX_TOP:
        begin
          next_aux[8] = wdata[AUX_TOP_BIT]; // [RULE2]
          next_fbyp = wdata[FB_BYP_BIT]; // [RULE12]
        end
        ADDR_IN_HI:
        begin
          next_inph = wdata[PHASE_LSB+:3]; // [RULE6]
          next_in[11:8] = wdata[3:0]; // [RULE7]
        end
        ADDR_IN_LO: next_in[7:0] = wdata; // [RULE7]
        ADDR_SS_TOP: next_ss[8] = wdata[SS_TOP_BIT]; // [RULE8]
        ADDR_SS_LO: next_ss[7:0] = wdata; // [RULE8]
        ADDR_DBL:
        begin
          next_dbl = wdata[DBL_BIT]; // [RULE10]
          next_pf = wdata[5:0]; // [RULE9]
        end
        // forbidden value still stored; software keeps it zero
        ADDR_OSC: next_osc = wdata[OSC_BIT]; // [RULE11]
        default: next_osc = osc_sel_q;
      endcase
    end
  end

  always_ff @(posedge clk_sys)
  begin
    if (!rst_b)
    begin
      main_feedback_ratio <= MAIN_FB_RST;
      aux_feedback_ratio <= AUX_FB_RST;
      aux_feedback_powerdown <= 1'b0;
      feedback_bypass <= 1'b0;
      input_prediv_ratio <= IN_DIV_RST;
      second_stage_ratio <= SS_RATIO_RST;
      second_stage_prediv <= SS_PREDIV_RST;
      freq_doubler_sel <= 1'b0;
      osc_sel_q <= 1'b0;
      fb_phase_q <= PHASE_RST;
      in_phase_q <= PHASE_RST;
    end
    else
    begin
      main_feedback_ratio <= next_main;
      aux_feedback_ratio <= next_aux;
      aux_feedback_powerdown <= next_pd;
      feedback_bypass <= next_fbyp;
      input_prediv_ratio <= next_in;
      second_stage_ratio <= next_ss;
      second_stage_prediv <= next_pf;
      freq_doubler_sel <= next_dbl;
      osc_sel_q <= next_osc;
      fb_phase_q <= next_fbph;
      in_phase_q <= next_inph;
    end
  end

  // =====================================================
  // register reads, reserved bits zero
  always_comb
  begin
    next_rdata = 8'h00;
    if (rd_en)
    begin
      unique case (addr)
        ADDR_FB_HI: next_rdata = {fb_phase_q, aux_feedback_powerdown,
          main_feedback_ratio[11:8]};
        ADDR_FB_LO: next_rdata = main_feedback_ratio[7:0];
        ADDR_AUX_LO: next_rdata = aux_feedback_ratio[7:0];
        ADDR_AUX_TOP: next_rdata = {aux_feedback_ratio[8], 6'h00,
          feedback_bypass};
        ADDR_IN_HI: next_rdata = {in_phase_q, 1'b0,
          input_prediv_ratio[11:8]} & MASK_IN_HI;
        ADDR_IN_LO: next_rdata = input_prediv_ratio[7:0];
        ADDR_SS_TOP: next_rdata = {7'h00, second_stage_ratio[8]};
        ADDR_SS_LO: next_rdata = second_stage_ratio[7:0];
        ADDR_DBL: next_rdata = {freq_doubler_sel, 1'b0,
          second_stage_prediv} & MASK_DBL;
        ADDR_OSC: next_rdata = {7'h00, osc_sel_q};
        default: next_rdata = 8'h00;
      endcase
    end
  end

  // =====================================================
  // divider chain
  dpd_divider #(.WIDTH(12)) u_in_div (
    .clk_sys(clk_sys), .rst_b(rst_b), .clk_en(ref_en),
    .run(!first_stage_bypass), .ratio(input_prediv_ratio), // [RULE7]
    .pulse(in_pulse));

  dpd_divider #(.WIDTH(12)) u_main_div (
    .clk_sys(clk_sys), .rst_b(rst_b), .clk_en(vcxo_en),
    .run(!first_stage_bypass), .ratio(main_feedback_ratio), // [RULE1]
    .pulse(main_pulse));

  // aux counts main pulses so bypass gives main times aux
  dpd_divider #(.WIDTH(9)) u_aux_div (
    .clk_sys(clk_sys), .rst_b(rst_b), .clk_en(main_pulse),
    .run(!aux_feedback_powerdown), // [RULE3]
    .ratio(aux_feedback_ratio), .pulse(aux_pulse)); // [RULE2]

  dpd_divider #(.WIDTH(6)) u_pf_div (
    .clk_sys(clk_sys), .rst_b(rst_b), .clk_en(vcxo_en),
    .run(second_stage_prediv != 6'h00),
    .ratio(second_stage_prediv), .pulse(pf_pulse)); // [RULE9]

  dpd_divider #(.WIDTH(9)) u_ss_div (
    .clk_sys(clk_sys), .rst_b(rst_b), .clk_en(vco_en),
    .run(1'b1), .ratio(second_stage_ratio), // [RULE8]
    .pulse(ss_pulse));

  // effective feedback ratio selection
  assign fb_pulse_c = feedback_bypass ? aux_pulse : main_pulse; // [RULE12]

  // doubler modelled as a pulse on both vcxo half cycles
  assign dbl_pulse = vcxo_en | vcxo_half;
  // bypassed prediv passes the vcxo clock straight through
  assign ss_src = freq_doubler_sel ? dbl_pulse : // [RULE10]
    ((second_stage_prediv == 6'h00) ? vcxo_en : pf_pulse); // [RULE9]
  assign next_ss_in = ss_src;
  assign next_fb = fb_pulse_c & !first_stage_bypass; // [RULE13]

  always_ff @(posedge clk_sys)
  begin
    if (!rst_b)
    begin
      vcxo_half <= 1'b0;
      rdata <= 8'h00;
      ref_div_pulse <= 1'b0;
      fb_div_pulse <= 1'b0;
      aux_div_pulse <= 1'b0;
      ss_in_pulse <= 1'b0;
      ss_fb_pulse <= 1'b0;
      feedback_phase_sel <= PHASE_RST;
      input_prediv_phase_sel <= PHASE_RST;
      first_stage_pll_en <= 1'b0;
      oscillator_select <= 1'b0;
    end
    else
    begin
      vcxo_half <= vcxo_en;
      rdata <= next_rdata;
      ref_div_pulse <= in_pulse;
      fb_div_pulse <= next_fb;
      aux_div_pulse <= aux_pulse;
      ss_in_pulse <= next_ss_in;
      ss_fb_pulse <= ss_pulse;
      feedback_phase_sel <= fb_phase_q; // [RULE4]
      input_prediv_phase_sel <= in_phase_q; // [RULE6]
      first_stage_pll_en <= !first_stage_bypass; // [RULE13]
      oscillator_select <= osc_sel_q; // [RULE11]
    end
  end
endmodule

// ==== sim/dpd_top_sva.sv ====
// assertion checker for the divider configuration block
module dpd_chk
  import dpd_pkg::*;
(
  input wire logic clk_sys, // block clock
  input wire logic rst_b, // sync reset
  input wire logic wr_en, // write strobe
  input wire logic rd_en, // read strobe
  input wire logic [7:0] addr, // address
  input wire logic [7:0] rdata, // read data
  input wire logic ref_en, // ref edge
  input wire logic vcxo_en, // vcxo edge
  input wire logic vco_en, // vco edge
  input wire logic ref_div_pulse, // ref out
  input wire logic ss_in_pulse, // ss input
  input wire logic ss_fb_pulse, // ss out
  input wire logic [2:0] feedback_phase_sel, // phase
  input wire logic [2:0] input_prediv_phase_sel, // phase
  input wire logic first_stage_pll_en, // pll on
  input wire logic oscillator_select // vco choice
);
  // ==========================================
  // properties
  default clocking @(posedge clk_sys); endclocking
  default disable iff (!rst_b);
  sequence s_rd(logic [7:0] a);
    rd_en && addr == a;
  endsequence
  // field copies may lag a write by a cycle
  sequence s_quiet;
    !wr_en && !$past(wr_en);
  endsequence
  a_fb_phase_copy: assert property (
    s_rd(ADDR_FB_HI) and s_quiet |=> rdata[7:5] == feedback_phase_sel)
    else $error("feedback phase copy differs");
  a_in_phase_copy: assert property (
    s_rd(ADDR_IN_HI) and s_quiet |=>
      rdata[7:5] == input_prediv_phase_sel && !rdata[4])
    else $error("input phase copy differs");
  a_osc_copy: assert property (
    s_rd(ADDR_OSC) and s_quiet |=> rdata == {7'h00, oscillator_select})
    else $error("oscillator copy differs");
  a_dbl_reserved: assert property (
    s_rd(ADDR_DBL) |=> !rdata[6]) else $error("reserved bit set");
  // divider flop plus output flop: the cause is two edges back; for the ss input it is one or two edges back
  a_ref_cause: assert property (
    ref_div_pulse |-> $past(ref_en, 2)) else $error("ref pulse uncaused");
  a_ss_in_cause: assert property (
    ss_in_pulse |-> $past(vcxo_en) || $past(vcxo_en, 2))
    else $error("ss input pulse uncaused");
  a_ss_fb_cause: assert property (
    ss_fb_pulse |-> $past(vco_en, 2)) else $error("ss pulse uncaused");
  a_pll_enabled: assert property (
    $past(rst_b) |-> first_stage_pll_en) else $error("pll off");
endmodule

bind dpd_top dpd_chk chk_u (.clk_sys, .rst_b, .wr_en, .rd_en, .addr,
  .rdata, .ref_en, .vcxo_en, .vco_en, .ref_div_pulse, .ss_in_pulse,
  .ss_fb_pulse, .feedback_phase_sel, .input_prediv_phase_sel,
  .first_stage_pll_en, .oscillator_select);

// ==== sim/tb_dpd_top.sv ====
// self-checking bench for the divider configuration block
module tb_dpd_top
  import dpd_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk_sys = 0, rst_b = 0, wr_en = 0, rd_en = 0;
  logic ref_en = 0, vcxo_en = 0, vco_en = 0;
  logic [7:0] addr = 8'h00, wdata = 8'h00, rdata;
  logic ref_div_pulse, fb_div_pulse, aux_div_pulse, ss_in_pulse;
  logic ss_fb_pulse, first_stage_pll_en, oscillator_select;
  logic [2:0] feedback_phase_sel, input_prediv_phase_sel;
  int n_mismatch = 0, n_compared = 0;
  always #12.5 clk_sys = ~clk_sys;
  dpd_top dut_u (.clk_sys, .rst_b, .wr_en, .rd_en, .addr, .wdata, .rdata,
    .ref_en, .vcxo_en, .vco_en, .ref_div_pulse, .fb_div_pulse,
    .aux_div_pulse, .ss_in_pulse, .ss_fb_pulse, .feedback_phase_sel,
    .input_prediv_phase_sel, .first_stage_pll_en, .oscillator_select);
  // ==========================================
  // helpers
  task automatic chk(input logic ok, input string m);
    n_compared++;
    if (ok !== 1'b1)
    begin
      n_mismatch++;
      $display("BAD %0t %s", $time, m);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk_sys);
    wr_en <= 1'b1;
    addr <= a;
    wdata <= d;
    @(posedge clk_sys);
    wr_en <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    @(posedge clk_sys);
    rd_en <= 1'b1;
    addr <= a;
    @(posedge clk_sys);
    rd_en <= 1'b0;
    @(negedge clk_sys);
    chk(rdata === e, "read data");
  endtask
  function automatic logic pk(input int k);
    case (k)
      0: return ref_div_pulse;
      1: return fb_div_pulse;
      2: return ss_fb_pulse;
      default: return ss_in_pulse;
    endcase
  endfunction
  // gap between two pulses with the source enabled every cycle
  task automatic meas(input int k, input int n);
    int g;
    @(posedge clk_sys);
    ref_en <= (k == 0);
    vcxo_en <= (k == 1 || k == 3);
    vco_en <= (k == 2);
    for (g = 0; g < 9000 && pk(k) !== 1'b1; g++) @(negedge clk_sys);
    @(negedge clk_sys);
    for (g = 1; g < 9000 && pk(k) !== 1'b1; g++) @(negedge clk_sys);
    chk(g == n, "divider gap");
    @(posedge clk_sys);
    {ref_en, vcxo_en, vco_en} <= 3'h0;
  endtask
  // ==========================================
  // scenarios
  task automatic t_regs;
    logic [7:0] ra[10] = '{ADDR_FB_HI, ADDR_FB_LO, ADDR_AUX_LO,
      ADDR_AUX_TOP, ADDR_IN_HI, ADDR_IN_LO, ADDR_SS_TOP, ADDR_SS_LO,
      ADDR_DBL, ADDR_OSC};
    logic [7:0] rv[10] = '{8'h0C, 8'h00, 8'h60, 8'h00, 8'h0C, 8'h00,
      8'h00, 8'h18, 8'h00, 8'h00};
    foreach (ra[i]) rd(ra[i], rv[i]);
    rd(8'h06, 8'h00);
    chk(first_stage_pll_en === 1'b1, "pll enabled");
    chk(oscillator_select === 1'b0, "oscillator select");
    wr(ADDR_AUX_TOP, 8'hFF);
    rd(ADDR_AUX_TOP, 8'h81);
    wr(ADDR_IN_HI, 8'hFF);
    rd(ADDR_IN_HI, MASK_IN_HI);
    chk(input_prediv_phase_sel === 3'h7, "input phase");
    wr(ADDR_DBL, 8'hFF);
    rd(ADDR_DBL, MASK_DBL);
    // main ratio is now 1024, so phase code 111 is the right pick
    wr(ADDR_FB_HI, 8'hE4);
    // phase output is a registered copy: one edge behind the field
    repeat (2) @(negedge clk_sys);
    chk(feedback_phase_sel === 3'h7, "feedback phase");
    rd(ADDR_FB_HI, 8'hE4);
    $display("done registers");
  endtask
  task automatic t_ratios;
    wr(ADDR_IN_HI, 8'h00);
    wr(ADDR_IN_LO, 8'h03);
    meas(0, 3);
    wr(ADDR_FB_HI, 8'h00);
    wr(ADDR_FB_LO, 8'h05);
    wr(ADDR_AUX_TOP, 8'h00);
    meas(1, 5);
    wr(ADDR_AUX_LO, 8'h04);
    wr(ADDR_AUX_TOP, 8'h01);
    meas(1, 20);
    wr(ADDR_SS_LO, 8'h08);
    meas(2, 8);
    wr(ADDR_DBL, 8'h03);
    meas(3, 3);
    wr(ADDR_DBL, 8'h00);
    meas(3, 1);
    $display("done ratios");
  endtask
  task automatic t_extra;
    int c = 0;
    wr(ADDR_DBL, 8'h83);
    @(posedge clk_sys);
    vcxo_en <= 1'b1;
    @(posedge clk_sys);
    vcxo_en <= 1'b0;
    repeat (6) @(negedge clk_sys) c += ss_in_pulse;
    chk(c == 2, "doubled pulses");
    wr(ADDR_FB_HI, 8'h10);
    c = 0;
    @(posedge clk_sys);
    vcxo_en <= 1'b1;
    repeat (300) @(negedge clk_sys) c += aux_div_pulse;
    chk(c == 0, "aux powered down");
    @(posedge clk_sys);
    vcxo_en <= 1'b0;
    $display("done extras");
  endtask
  task automatic report_and_stop;
    $display("compared %0d mismatched %0d", n_compared, n_mismatch);
    if (n_mismatch == 0 && n_compared > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask
  // ==========================================
  // sequence and watchdog
  initial
  begin
    repeat (2) @(posedge clk_sys);
    rst_b <= 1'b1;
    t_regs;
    t_ratios;
    t_extra;
    report_and_stop;
  end
  initial
  begin
    #2000000;
    n_mismatch++;
    report_and_stop;
  end
endmodule
